// >>> plc_line_control.sv
// Parallel line control: per-line ownership, drive, filter and level registers behind AXI4-Lite
//
// Operation
// - Writing one to line_ctrl_enable gives that pin to port logic.
// - Writing one to line_ctrl_disable hands that pin to the peripheral.
// - line_ctrl_status reads 1 for port ownership, 0 for peripheral.
// - Writing one to drive_enable_set turns on that line's driver.
// - Writing one to drive_enable_clear turns the driver off, input only.
// - drive_enable_status reads 1 when driver enabled, 0 when input only.
// - Writing one to glitch_filter_set inserts the glitch filter.
// - Writing one to glitch_filter_clear bypasses the glitch filter.
// - glitch_filter_status reads 1 while filter active, 0 when bypassed.
// - Writing one to drive_level_set makes the scheduled level high.
// - Writing one to drive_level_clear makes the scheduled level low.
// - drive_level_status returns the scheduled drive level per line.
// - drive_level_status is readable and writable for some lines.
// - Direct writes change only lines enabled in direct_write_status.
// - pin_level_status reports the sampled pin level, whoever drives it.
// - Unimplemented line bits ignore writes and read zero.
`timescale 1ns/1ps
`default_nettype none
module plc_line_control (
	input  wire logic                          aclk,          // System clock
	input  wire logic                          aresetn,       // Synchronous reset, active low
	input  wire logic [plc_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,  // Write address
	input  wire logic                          s_axi_awvalid, // Write address valid
	output logic                               s_axi_awready, // Write address ready
	input  wire logic [plc_pkg::DATA_WIDTH-1:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]                    s_axi_wstrb,   // Write byte strobes
	input  wire logic                          s_axi_wvalid,  // Write data valid
	output logic                               s_axi_wready,  // Write data ready
	output logic [1:0]                         s_axi_bresp,   // Write response
	output logic                               s_axi_bvalid,  // Write response valid
	input  wire logic                          s_axi_bready,  // Write response ready
	input  wire logic [plc_pkg::ADDR_WIDTH-1:0] s_axi_araddr,  // Read address
	input  wire logic                          s_axi_arvalid, // Read address valid
	output logic                               s_axi_arready, // Read address ready
	output logic [plc_pkg::DATA_WIDTH-1:0]     s_axi_rdata,   // Read data
	output logic [1:0]                         s_axi_rresp,   // Read response
	output logic                               s_axi_rvalid,  // Read data valid
	input  wire logic                          s_axi_rready,  // Read data ready
	input  wire logic [31:0]                   pad_in,        // Pin levels as seen at the pads
	output plc_pkg::plc_pad_type               pad_out,       // Pin level and active-low drive enable
	input  wire plc_pkg::plc_pad_type          periph_out,    // Peripheral level and active-low enable
	output logic [31:0]                        periph_in      // Pin levels handed to peripherals
);
	import plc_pkg::*;

	// ----------------------------------------------------------------
	// Line configuration state
	// ----------------------------------------------------------------
	logic [31:0] line_ctrl_q;
	logic [31:0] drive_en_q;
	logic [31:0] filter_en_q;
	logic [31:0] drive_lvl_q;
	logic [31:0] direct_wr_q;

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	logic [7:0]  aw_addr_q;
	logic        aw_held_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_held_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// ----------------------------------------------------------------
	// Input sampling state
	// ----------------------------------------------------------------
	logic [31:0] pin_now_q;
	logic [31:0] pin_prev_q;
	logic [31:0] pin_stable_q;
	logic [31:0] pin_level;

	// ----------------------------------------------------------------
	// Pad output state
	// ----------------------------------------------------------------
	logic [31:0] pad_level_q;
	logic [31:0] pad_drive_n_q;
	logic [31:0] periph_in_q;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic        wr_fire;
	logic [31:0] wr_ones;
	logic        wr_hit;

	// Byte lanes not strobed count as zeros: set and clear writes leave them alone, a direct write clears its opened lines there
	assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_ones = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}}
		& w_data_q & LINE_IMPL;

	// A write to an unmapped offset is still completed so the master
	// never hangs; only the response code tells it apart
	always_comb begin
		unique case (aw_addr_q)
			OFS_LINE_CTRL_ENABLE, OFS_LINE_CTRL_DISABLE, OFS_LINE_CTRL_STATUS,
			OFS_DRIVE_ENABLE_SET, OFS_DRIVE_ENABLE_CLEAR, OFS_DRIVE_ENABLE_STATUS,
			OFS_GLITCH_FILTER_SET, OFS_GLITCH_FILTER_CLEAR, OFS_GLITCH_FILTER_STATUS,
			OFS_DRIVE_LEVEL_SET, OFS_DRIVE_LEVEL_CLEAR, OFS_DRIVE_LEVEL_STATUS,
			OFS_PIN_LEVEL_STATUS, OFS_CHANGE_IRQ_ENABLE,
			OFS_DIRECT_WRITE_SET, OFS_DIRECT_WRITE_CLEAR, OFS_DIRECT_WRITE_STATUS: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Ownership
	// ----------------------------------------------------------------
	// Lines with no peripheral behind them stay owned by port logic
	// Limitation: ownership moves one edge after the write lands, and
	// the pads follow one edge later still
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_ctrl_q <= LINE_CTRL_RST;
		end else if (wr_fire) begin
			if (aw_addr_q == OFS_LINE_CTRL_ENABLE) begin
				line_ctrl_q <= line_ctrl_q | wr_ones;
			end else if (aw_addr_q == OFS_LINE_CTRL_DISABLE) begin
				line_ctrl_q <= line_ctrl_q & ~(wr_ones & LINE_MUXED);
			end
		end
	end

	// ----------------------------------------------------------------
	// Output driver enable
	// ----------------------------------------------------------------
	// The enable only reaches the pad while port logic owns the line;
	// a peripheral line keeps its own enable, so this state is kept
	// but has no effect until ownership returns
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_en_q <= DRIVE_EN_RST;
		end else if (wr_fire) begin
			if (aw_addr_q == OFS_DRIVE_ENABLE_SET) begin
				drive_en_q <= drive_en_q | wr_ones;
			end else if (aw_addr_q == OFS_DRIVE_ENABLE_CLEAR) begin
				drive_en_q <= drive_en_q & ~wr_ones;
			end
		end
	end

	// ----------------------------------------------------------------
	// Glitch filter enable
	// ----------------------------------------------------------------
	// Filter state is kept for peripheral lines too, since the filter
	// sits on the input path that both owners share
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filter_en_q <= FILTER_RST;
		end else if (wr_fire) begin
			if (aw_addr_q == OFS_GLITCH_FILTER_SET) begin
				filter_en_q <= filter_en_q | wr_ones;
			end else if (aw_addr_q == OFS_GLITCH_FILTER_CLEAR) begin
				filter_en_q <= filter_en_q & ~wr_ones;
			end
		end
	end

	// ----------------------------------------------------------------
	// Scheduled drive level
	// ----------------------------------------------------------------
	// A direct write replaces only lines opened for it; a masked write
	// keeps read-modify-write races off the other lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_lvl_q <= DRIVE_LVL_RST;
		end else if (wr_fire) begin
			if (aw_addr_q == OFS_DRIVE_LEVEL_SET) begin
				drive_lvl_q <= drive_lvl_q | wr_ones;
			end else if (aw_addr_q == OFS_DRIVE_LEVEL_CLEAR) begin
				drive_lvl_q <= drive_lvl_q & ~wr_ones;
			end else if (aw_addr_q == OFS_DRIVE_LEVEL_STATUS) begin
				drive_lvl_q <= (drive_lvl_q & ~direct_wr_q) | (wr_ones & direct_wr_q);
			end
		end
	end

	// ----------------------------------------------------------------
	// Direct-write enable
	// ----------------------------------------------------------------
	// Lines stay closed to direct writes after reset, so a stray write
	// to the drive level status word cannot move any pin until software
	// opens lines on purpose
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			direct_wr_q <= DIRECT_WR_RST;
		end else if (wr_fire) begin
			if (aw_addr_q == OFS_DIRECT_WRITE_SET) begin
				direct_wr_q <= direct_wr_q | wr_ones;
			end else if (aw_addr_q == OFS_DIRECT_WRITE_CLEAR) begin
				direct_wr_q <= direct_wr_q & ~wr_ones;
			end
		end
	end

	// ----------------------------------------------------------------
	// Input sampling and glitch filter
	// ----------------------------------------------------------------
	// Filtered level only follows a pin that held for two samples, so a
	// one-cycle glitch never reaches software or the peripheral
	// Trade-off: a filtered line answers two cycles later than a bypassed
	// one; pulses of exactly one cycle are the only ones rejected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_now_q    <= 32'h0000_0000;
			pin_prev_q   <= 32'h0000_0000;
			pin_stable_q <= 32'h0000_0000;
		end else begin
			pin_now_q    <= pad_in;
			pin_prev_q   <= pin_now_q;
			pin_stable_q <= (pin_stable_q & (pin_now_q ^ pin_prev_q))
				| (pin_now_q & ~(pin_now_q ^ pin_prev_q));
		end
	end

	assign pin_level = ((filter_en_q & pin_stable_q) | (~filter_en_q & pin_now_q)) & LINE_IMPL;

	// ----------------------------------------------------------------
	// Pad multiplexer
	// ----------------------------------------------------------------
	// Pads are registered so every pin changes on a clock edge, never
	// through a path from the bus or from a peripheral; the price is one
	// cycle of delay on every peripheral output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_level_q   <= 32'h0000_0000;
			pad_drive_n_q <= ALL_DRIVE_OFF;
			periph_in_q   <= 32'h0000_0000;
		end else begin
			pad_level_q   <= (line_ctrl_q & drive_lvl_q) | (~line_ctrl_q & periph_out.level);
			pad_drive_n_q <= (line_ctrl_q & ~drive_en_q) | (~line_ctrl_q & periph_out.drive_n) | ~LINE_IMPL;
			periph_in_q   <= pin_level;
		end
	end

	assign pad_out.level   = pad_level_q;
	assign pad_out.drive_n = pad_drive_n_q;
	assign periph_in       = periph_in_q;

	// ----------------------------------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------------------------------
	// Address and data are taken in either order; each ready drops once
	// its item is held and returns after the response is taken
	// Only one write is open at a time, which keeps the decode simple
	// and costs nothing for a port that software touches rarely
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q <= 8'h00;
			aw_held_q <= 1'b0;
			awready_q <= 1'b1;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			w_held_q  <= 1'b0;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (awready_q && s_axi_awvalid) begin
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
				aw_held_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (wready_q && s_axi_wvalid) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// ----------------------------------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic [1:0]  rd_resp;

	// Write-only registers read zero; unmapped addresses answer SLVERR
	// Read data is captured at the address handshake, so a pin level
	// is a snapshot of the cycle in which the address was taken
	always_comb begin
		rd_resp = RESP_OKAY;
		unique case ({s_axi_araddr[7:2], 2'b00})
			OFS_LINE_CTRL_STATUS: begin
				rd_word = (line_ctrl_q | ~LINE_MUXED) & LINE_IMPL;
			end
			OFS_DRIVE_ENABLE_STATUS: begin
				rd_word = drive_en_q & LINE_IMPL;
			end
			OFS_GLITCH_FILTER_STATUS: begin
				rd_word = filter_en_q & LINE_IMPL;
			end
			OFS_DRIVE_LEVEL_STATUS: begin
				rd_word = drive_lvl_q & LINE_IMPL;
			end
			OFS_PIN_LEVEL_STATUS: begin
				rd_word = pin_level;
			end
			OFS_DIRECT_WRITE_STATUS: begin
				rd_word = direct_wr_q & LINE_IMPL;
			end
			OFS_LINE_CTRL_ENABLE, OFS_LINE_CTRL_DISABLE,
			OFS_DRIVE_ENABLE_SET, OFS_DRIVE_ENABLE_CLEAR,
			OFS_GLITCH_FILTER_SET, OFS_GLITCH_FILTER_CLEAR,
			OFS_DRIVE_LEVEL_SET, OFS_DRIVE_LEVEL_CLEAR, OFS_CHANGE_IRQ_ENABLE,
			OFS_DIRECT_WRITE_SET, OFS_DIRECT_WRITE_CLEAR: begin
				rd_word = 32'h0000_0000;
			end
			default: begin
				rd_word = 32'h0000_0000;
				rd_resp = RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else if (arready_q && s_axi_arvalid) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= rd_resp;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

endmodule
`default_nettype wire

// >>> plc_line_control_props.sv
// Checker: bus handshake and pin timing properties of the line control block
`timescale 1ns/1ps
`default_nettype none
module plc_line_control_props (
	input wire logic                           aclk,          // clock
	input wire logic                           aresetn,       // reset, active low
	input wire logic [plc_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,  // aw
	input wire logic                           s_axi_awvalid, // aw
	input wire logic                           s_axi_awready, // aw
	input wire logic [plc_pkg::DATA_WIDTH-1:0] s_axi_wdata,   // w
	input wire logic [3:0]                     s_axi_wstrb,   // w
	input wire logic                           s_axi_wvalid,  // w
	input wire logic                           s_axi_wready,  // w
	input wire logic [1:0]                     s_axi_bresp,   // b
	input wire logic                           s_axi_bvalid,  // b
	input wire logic                           s_axi_bready,  // b
	input wire logic [plc_pkg::ADDR_WIDTH-1:0] s_axi_araddr,  // ar
	input wire logic                           s_axi_arvalid, // ar
	input wire logic                           s_axi_arready, // ar
	input wire logic [plc_pkg::DATA_WIDTH-1:0] s_axi_rdata,   // r
	input wire logic [1:0]                     s_axi_rresp,   // r
	input wire logic                           s_axi_rvalid,  // r
	input wire logic                           s_axi_rready,  // r
	input wire logic [31:0]                    pad_in,        // pins
	input wire plc_pkg::plc_pad_type           pad_out,       // pad drive
	input wire plc_pkg::plc_pad_type           periph_out,    // peripheral drive
	input wire logic [31:0]                    periph_in      // to peripherals
);
	import plc_pkg::*;

	// ----------------------------------------------------------------
	// Ownership shadow, rebuilt from full-word writes seen on the bus
	// ----------------------------------------------------------------
	logic [31:0] own_q;
	logic        wr_hs;
	assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hF;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			own_q <= LINE_CTRL_RST;
		end else if (wr_hs && s_axi_awaddr == OFS_LINE_CTRL_ENABLE) begin
			own_q <= own_q | s_axi_wdata;
		end else if (wr_hs && s_axi_awaddr == OFS_LINE_CTRL_DISABLE) begin
			own_q <= own_q & ~s_axi_wdata;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address accepted while a write is open");
	a_b_answer: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0C
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("reserved read not refused");
	a_wo_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_DRIVE_LEVEL_SET
		|=> s_axi_rresp == RESP_OKAY && s_axi_rdata == 32'h0)
		else $error("write-only register read nonzero");
	a_drive_off: assert property (wr_hs && s_axi_awaddr == OFS_DRIVE_ENABLE_CLEAR
		|-> ##3 (~pad_out.drive_n & own_q & $past(s_axi_wdata, 3)) == 32'h0)
		else $error("driver still on after clear");
	a_level_high: assert property (wr_hs && s_axi_awaddr == OFS_DRIVE_LEVEL_SET
		|-> ##3 (~pad_out.level & ~pad_out.drive_n & own_q & $past(s_axi_wdata, 3)) == 32'h0)
		else $error("driven level not high after set");
	a_periph_pass: assert property (own_q == $past(own_q, 3)
		|-> (((pad_out.level ^ $past(periph_out.level)) | (pad_out.drive_n ^ $past(periph_out.drive_n)))
		& ~own_q) == 32'h0)
		else $error("peripheral line not passed through");
endmodule
`default_nettype wire

// >>> plc_pins_model.sv
// Partner: pads with outside drivers and a peripheral that keeps changing its outputs
`timescale 1ns/1ps
`default_nettype none
module plc_pins_model (
	input wire logic                 aclk,       // clock
	input wire plc_pkg::plc_pad_type pad_out,    // block drive
	input wire logic [31:0]          ext_level,  // outside level
	input wire logic [31:0]          ext_en,     // outside driver present
	output logic [31:0]              pad_in,     // resolved pins
	output plc_pkg::plc_pad_type     periph_out  // peripheral drive
);
	import plc_pkg::*;
	// Lines nobody drives have no pull, so they wander rather than keep a value
	logic [31:0] float_q = 32'h5555_5555;
	logic [31:0] per_q   = 32'h0000_0000;
	always_ff @(posedge aclk) begin
		float_q <= ~float_q;
		per_q   <= per_q + 32'h0001_0003;
	end
	assign pad_in = (~pad_out.drive_n & pad_out.level) | (pad_out.drive_n & ext_en & ext_level)
		| (pad_out.drive_n & ~ext_en & float_q);
	assign periph_out.level   = per_q;
	assign periph_out.drive_n = ~per_q;
endmodule
`default_nettype wire

// >>> plc_pkg.sv
// Package: register map, reset values and carrier types for the parallel line control block
`default_nettype none
package plc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned LINES      = 32;
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 32;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_LINE_CTRL_ENABLE     = 8'h00;
	localparam logic [7:0] OFS_LINE_CTRL_DISABLE    = 8'h04;
	localparam logic [7:0] OFS_LINE_CTRL_STATUS     = 8'h08;
	localparam logic [7:0] OFS_DRIVE_ENABLE_SET     = 8'h10;
	localparam logic [7:0] OFS_DRIVE_ENABLE_CLEAR   = 8'h14;
	localparam logic [7:0] OFS_DRIVE_ENABLE_STATUS  = 8'h18;
	localparam logic [7:0] OFS_GLITCH_FILTER_SET    = 8'h20;
	localparam logic [7:0] OFS_GLITCH_FILTER_CLEAR  = 8'h24;
	localparam logic [7:0] OFS_GLITCH_FILTER_STATUS = 8'h28;
	localparam logic [7:0] OFS_DRIVE_LEVEL_SET      = 8'h30;
	localparam logic [7:0] OFS_DRIVE_LEVEL_CLEAR    = 8'h34;
	localparam logic [7:0] OFS_DRIVE_LEVEL_STATUS   = 8'h38;
	localparam logic [7:0] OFS_PIN_LEVEL_STATUS     = 8'h3C;
	localparam logic [7:0] OFS_CHANGE_IRQ_ENABLE    = 8'h40;
	localparam logic [7:0] OFS_DIRECT_WRITE_SET     = 8'hA0;
	localparam logic [7:0] OFS_DIRECT_WRITE_CLEAR   = 8'hA4;
	localparam logic [7:0] OFS_DIRECT_WRITE_STATUS  = 8'hA8;

	// ----------------------------------------------------------------
	// Line population and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] LINE_IMPL      = 32'hFFFF_FFFF;
	localparam logic [31:0] LINE_MUXED     = 32'hFFFF_FFFF;
	localparam logic [31:0] LINE_CTRL_RST  = 32'hFFFF_FFFF;
	localparam logic [31:0] DRIVE_EN_RST   = 32'h0000_0000;
	localparam logic [31:0] FILTER_RST     = 32'h0000_0000;
	localparam logic [31:0] DRIVE_LVL_RST  = 32'h0000_0000;
	localparam logic [31:0] DIRECT_WR_RST  = 32'h0000_0000;
	localparam logic [31:0] ALL_DRIVE_OFF  = 32'hFFFF_FFFF;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Carrier: one level and one active-low drive enable per line
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] level;
		logic [31:0] drive_n;
	} plc_pad_type;

endpackage
`default_nettype wire

// >>> tb_top.sv
// Testbench: register scenarios over AXI4-Lite with pin and filter checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import plc_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, ext_level = 32'h1234_5678, ext_en = 32'hFFFF_FFFF;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, pad_in, periph_in;
	plc_pad_type pad_out, periph_out;
	int fails = 0, cmp_count = 0;

	always #5 aclk = ~aclk;

	plc_line_control u_plc_line_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pad_in, .pad_out, .periph_out, .periph_in);
	plc_pins_model u_plc_pins_model (.aclk, .pad_out, .ext_level, .ext_en, .pad_in, .periph_out);

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) print_verdict_on_hang();
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	// Read stalls rready one cycle so the slave must hold its answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF,
		input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) print_verdict_on_hang();
		chk(s_axi_rdata & m, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	task automatic print_verdict_on_hang;
		fails++;
		$display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		print_verdict;
	endtask

	task automatic t_reset;
		rd(OFS_LINE_CTRL_STATUS, 32'hFFFF_FFFF);
		rd(OFS_DRIVE_ENABLE_STATUS, 32'h0);
		rd(OFS_GLITCH_FILTER_STATUS, 32'h0);
		rd(OFS_DRIVE_LEVEL_STATUS, 32'h0);
		rd(OFS_DIRECT_WRITE_STATUS, 32'h0);
		rd(OFS_DRIVE_LEVEL_SET, 32'h0);
		rd(8'h0C, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
		$display("test reset done");
	endtask

	task automatic t_own;
		wr(OFS_LINE_CTRL_DISABLE, 32'h0000_FF00);
		rd(OFS_LINE_CTRL_STATUS, 32'hFFFF_00FF);
		wr(OFS_LINE_CTRL_ENABLE, 32'h0000_0F00);
		rd(OFS_LINE_CTRL_STATUS, 32'hFFFF_0FFF);
		$display("test ownership done");
	endtask

	task automatic t_drive;
		wr(OFS_DRIVE_ENABLE_SET, 32'h0000_00FF);
		rd(OFS_DRIVE_ENABLE_STATUS, 32'h0000_00FF);
		wr(OFS_DRIVE_ENABLE_CLEAR, 32'h0000_000F);
		rd(OFS_DRIVE_ENABLE_STATUS, 32'h0000_00F0);
		wr(OFS_DRIVE_LEVEL_SET, 32'h0000_F0F0);
		wr(OFS_DRIVE_LEVEL_CLEAR, 32'h0000_3000);
		rd(OFS_DRIVE_LEVEL_STATUS, 32'h0000_C0F0);
		// Lines 7:4 are driven high; peripheral lines 15:12 are masked out
		rd(OFS_PIN_LEVEL_STATUS, 32'h1234_06F8, 32'hFFFF_0FFF);
		$display("test drive done");
	endtask

	task automatic t_direct;
		wr(OFS_DIRECT_WRITE_SET, 32'h0000_000F);
		rd(OFS_DIRECT_WRITE_STATUS, 32'h0000_000F);
		wr(OFS_DRIVE_LEVEL_STATUS, 32'h0000_FF05);
		rd(OFS_DRIVE_LEVEL_STATUS, 32'h0000_C0F5);
		wr(OFS_DIRECT_WRITE_CLEAR, 32'h0000_0003);
		rd(OFS_DIRECT_WRITE_STATUS, 32'h0000_000C);
		// Only byte 1 is strobed, so lines 15:8 alone are set
		s_axi_wstrb <= 4'h2;
		wr(OFS_DRIVE_LEVEL_SET, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'hF;
		rd(OFS_DRIVE_LEVEL_STATUS, 32'h0000_FFF5);
		wr(OFS_LINE_CTRL_STATUS, 32'h0);
		rd(OFS_LINE_CTRL_STATUS, 32'hFFFF_0FFF);
		wr(8'h0C, 32'hFFFF_FFFF, RESP_SLVERR);
		$display("test direct write done");
	endtask

	task automatic pulse_line0(input logic [31:0] e);
		logic g;
		g = 1'b0;
		@(posedge aclk);
		ext_level[0] <= 1'b1;
		@(posedge aclk);
		ext_level[0] <= 1'b0;
		repeat (6) begin
			@(posedge aclk);
			g = g | periph_in[0];
		end
		chk({31'h0, g}, e);
	endtask

	task automatic t_filter;
		wr(OFS_GLITCH_FILTER_SET, 32'h0000_0001);
		rd(OFS_GLITCH_FILTER_STATUS, 32'h0000_0001);
		pulse_line0(32'h0);
		wr(OFS_GLITCH_FILTER_CLEAR, 32'h0000_0001);
		rd(OFS_GLITCH_FILTER_STATUS, 32'h0);
		pulse_line0(32'h1);
		$display("test filter done");
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_own();
		t_drive();
		t_direct();
		t_filter();
		print_verdict();
	end
endmodule

bind plc_line_control plc_line_control_props u_plc_line_control_props (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .periph_out, .periph_in);
`default_nettype wire
